//--- dv/swrs_ctrl_bench.sv
/*
 Self-checking bench for swrs_ctrl: register table, then switch, stop,
 protection, fatal fault and reset cases. Assumes the switch model.
*/
`timescale 1ns/10ps
module swrs_ctrl_bench;
   import swrs_pkg::*;
   typedef struct packed {
      logic we;
      logic [3:0] adr;
      logic [31:0] dat;
   } swrs_row_type;
   logic mclk_i = 1'b0;
   logic resetn_i = 1'b0;
   swrs_wb_req_type req = '0;
   logic want_run = 1'b0;
   logic run_switch, ack, contact, exec, io, comms, dflt, flash, mp, led;
   logic flog;
   logic [1:0] fcode;
   logic [1:0] last_code = 2'h0;
   logic [31:0] dat_o, rd;
   int n_mismatch = 0;
   int check_count = 0;
   // Reads carry the expected value in dat
   swrs_row_type rows [16] = '{
      '{1'b0, ADR_CTRL, 32'h208}, '{1'b0, ADR_SWEEP, 32'h64},
      '{1'b0, ADR_STATUS, 32'h1}, '{1'b0, 4'h2, 32'h0},
      '{1'b1, ADR_SWEEP, 32'h4}, '{1'b0, ADR_SWEEP, 32'h64},
      '{1'b1, ADR_SWEEP, 32'h5}, '{1'b0, ADR_SWEEP, 32'h5},
      '{1'b1, ADR_SWEEP, 32'h1F5}, '{1'b0, ADR_SWEEP, 32'h5},
      '{1'b1, ADR_SWEEP, 32'h1F4}, '{1'b0, ADR_SWEEP, 32'h1F4},
      '{1'b1, ADR_CTRL, 32'hF}, '{1'b0, ADR_CTRL, 32'h20F},
      '{1'b1, ADR_CMD, 32'h40}, '{1'b0, ADR_CTRL, 32'h3CF}};

   always #2 mclk_i = ~mclk_i;
   always @(posedge mclk_i) if (flog) last_code <= fcode;

   swrs_switch_model sw (.mclk_i(mclk_i), .want_run_i(want_run),
      .run_switch_o(run_switch));
   swrs_ctrl dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
      .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
      .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .run_switch_i(run_switch),
      .oversweep_contact_o(contact), .logic_exec_o(exec), .io_scan_o(io),
      .comms_en_o(comms), .outputs_default_o(dflt),
      .load_flash_o(flash), .mem_protect_o(mp), .run_led_o(led),
      .fault_log_o(flog), .fault_code_o(fcode));

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out

   task automatic check(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Ack is read right after the edge, so it is the value that edge sampled
   task automatic wb(input logic we, input logic [3:0] adr,
         input logic [31:0] dat, output logic [31:0] q);
      int n;
      req <= '{cyc:1'b1, stb:1'b1, we:we, sel:4'hF, adr:adr, dat:dat};
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) begin
         n_mismatch++;
         close_out();
      end
      q = dat_o;
      req <= '0;
      @(posedge mclk_i);
   endtask : wb

   task automatic wait_for(input logic val);
      int n;
      n = 0;
      while (exec !== val && n < 20) begin
         @(posedge mclk_i);
         n++;
      end
      check("logic_exec_o", {31'h0, val}, {31'h0, exec});
   endtask : wait_for

   initial begin
      repeat (100000) @(posedge mclk_i);
      n_mismatch++;
      close_out();
   end

   initial begin
      repeat (20) @(posedge mclk_i);
      resetn_i <= 1'b1;
      @(posedge mclk_i);
      foreach (rows[i]) begin
         wb(rows[i].we, rows[i].adr, rows[i].dat, rd);
         if (!rows[i].we) check("register", rows[i].dat, rd);
      end
      check("load_flash_o", 32'h1, {31'h0, flash});
      $display("test table done");
      want_run <= 1'b1;
      wait_for(1'b1);
      check("run_led_o", 32'h1, {31'h0, led});
      want_run <= 1'b0;
      wait_for(1'b0);
      wb(1'b0, ADR_STATUS, 32'h0, rd);
      check("stop mode", 32'h2, {30'h0, rd[1:0]});
      check("io_scan_o", 32'h1, {31'h0, io});
      wb(1'b1, ADR_CMD, 32'h10, rd);
      want_run <= 1'b1;
      wait_for(1'b1);
      wb(1'b0, ADR_STATUS, 32'h0, rd);
      check("status", 32'hA0, rd);
      $display("test switch done");
      wb(1'b1, ADR_CMD, 32'h2, rd);
      repeat (5) @(posedge mclk_i);
      check("still running", 32'h1, {31'h0, exec});
      wb(1'b1, ADR_CMD, 32'h1, rd);
      wait_for(1'b0);
      check("outputs_default_o", 32'h1, {31'h0, dflt});
      check("fault code", 32'h2, {30'h0, last_code});
      want_run <= 1'b0;
      repeat (5) @(posedge mclk_i);
      wb(1'b1, ADR_CMD, 32'h4, rd);
      repeat (10) @(posedge mclk_i);
      check("run refused", 32'h0, {31'h0, exec});
      $display("test stop done");
      wb(1'b1, ADR_CTRL, 32'h1F, rd);
      wb(1'b1, ADR_CMD, 32'h40, rd);
      check("mem_protect_o", 32'h1, {31'h0, mp});
      wb(1'b1, ADR_CTRL, 32'h0, rd);
      wb(1'b0, ADR_CTRL, 32'h0, rd);
      check("ctrl locked", 32'h7DF, rd);
      wb(1'b1, ADR_CMD, 32'h8, rd);
      want_run <= 1'b1;
      repeat (6) @(posedge mclk_i);
      wb(1'b0, ADR_STATUS, 32'h0, rd);
      check("fault mode", 32'h3, {30'h0, rd[1:0]});
      check("blink", 32'h1, {31'h0, rd[4]});
      check("no run yet", 32'h0, {31'h0, exec});
      check("run_led_o blink", 32'h1, {31'h0, led});
      $display("test protect fault done");
      resetn_i <= 1'b0;
      @(posedge mclk_i);
      check("reset default", 32'h1, {31'h0, dflt});
      repeat (3) @(posedge mclk_i);
      resetn_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      check("comms_en_o", 32'h1, {31'h0, comms});
      wb(1'b0, ADR_CTRL, 32'h0, rd);
      check("ctrl reset", 32'h208, rd);
      check("mp reset", 32'h0, {31'h0, mp});
      $display("test reset done");
      close_out();
   end
endmodule : swrs_ctrl_bench

bind swrs_ctrl swrs_ctrl_sva chk (.mclk_i(mclk_i), .resetn_i(resetn_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .logic_exec_o(logic_exec_o),
   .io_scan_o(io_scan_o), .comms_en_o(comms_en_o),
   .outputs_default_o(outputs_default_o), .fault_log_o(fault_log_o),
   .fault_code_o(fault_code_o));

//--- dv/swrs_ctrl_sva.sv
/*
 Checker for swrs_ctrl: bus answer timing, mode outputs, fault log.
 Assumes it is bound to the ports of swrs_ctrl.
*/
`timescale 1ns/10ps
module swrs_ctrl_sva (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic logic_exec_o,
   input wire logic io_scan_o,
   input wire logic comms_en_o,
   input wire logic outputs_default_o,
   input wire logic fault_log_o,
   input wire logic [1:0] fault_code_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   a_ack_after_req: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack one cycle after request");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero without ack");
   a_comms_kept_on: assert property ($past(resetn_i) |-> comms_en_o)
      else $error("comms not serviced");
   a_run_scans_io: assert property (
      logic_exec_o |-> io_scan_o && !outputs_default_o)
      else $error("run without I/O scan");
   a_default_no_exec: assert property (
      outputs_default_o |-> !logic_exec_o)
      else $error("logic runs with outputs at defaults");
   a_stop_io_live: assert property (
      io_scan_o && !logic_exec_o |-> !outputs_default_o)
      else $error("stop with I/O holds outputs at defaults");
   a_log_code_known: assert property (
      fault_log_o |-> fault_code_o == 2'h1 || fault_code_o == 2'h2)
      else $error("fault log code unknown");
   a_log_one_pulse: assert property (fault_log_o |=> !fault_log_o)
      else $error("fault log pulse too long");
endmodule : swrs_ctrl_sva

//--- dv/swrs_switch_model.sv
/*
 Operator run/stop switch model; position follows the bench's request.
 Assumes the bench changes the request only after a clock edge.
*/
`timescale 1ns/10ps
module swrs_switch_model (
   input wire logic mclk_i,
   input wire logic want_run_i,
   output logic run_switch_o
);
   // Hold periods are set by the bench; real half second holds are too long
   always_ff @(posedge mclk_i) begin
      run_switch_o <= want_run_i;
   end
endmodule : swrs_switch_model

//--- src/swrs_ctrl.sv
/*
 Sweep timing and run/stop controller with a classic Wishbone slave.
 Assumes the run/stop switch pin is asynchronous to mclk_i and that the
 sweep sequencer reports the end of each sweep by a command write.
*/
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
// Summary of operation
// - Constant sweep mode holds each sweep to a 5 to 500 ms timer.
// - On timer expiry the sweep still runs all its remaining phases.
// - The sweep after an overrun logs an oversweep fault entry.
// - The second sweep after an overrun sets the oversweep contact.
// - The contact clears once a sweep no longer overruns.
// - The contact clears whenever constant sweep mode is off.
// - Default sweep mode edits only in stop, effective after store.
// - Stop runs no logic; a setting picks I/O scanned or not.
// - Communications, fault polling, reconfiguration go on in stop.
// - Program stop request stops after next sweep, outputs default, logs.
// - Powerup loads from RAM, or from flash when configured.
// - Reset: switch run/stop enabled, switch memory protection off.
// - Non-fatal faults only: switch to Run enters Run, faults kept.
// - Fatal stop-fault: switch to Run blinks the run LED 5 s.
// - Run half s, Stop half s, Run in window clears faults, runs.
// - Window missed: LED off, stop-fault kept, faults kept.
// - Switch enabled and at Stop: no transition to Run.
// - Switch Run to Stop enters I/O or no-I/O stop per setting.
// - Switch memory protection blocks writes and forcing; here it blocks ctrl writes and store, not sweep time writes.
module swrs_ctrl
   import swrs_pkg::*;
(
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic run_switch_i,
   output logic oversweep_contact_o,
   output logic logic_exec_o,
   output logic io_scan_o,
   output logic comms_en_o,
   output logic outputs_default_o,
   output logic load_flash_o,
   output logic mem_protect_o,
   output logic run_led_o,
   output logic fault_log_o,
   output logic [1:0] fault_code_o
);
   swrs_wb_req_type req;
   logic [5:0] ctrl;
   logic [5:0] active;
   logic [8:0] sweep_ms;
   swrs_mode_type mode;
   logic sw_meta, sw_sync, sw_prev;
   logic fatal, nonfatal;
   logic [31:0] sweep_cnt;
   logic [8:0] sweep_ms_cnt;
   logic overrun, pend_log, pend_contact, stop_pend;
   logic [31:0] blink_cnt, hold_cnt;
   logic [1:0] clr_step;
   logic blink_on;
   logic [31:0] half_cnt;
   logic blink_phase;
   logic prog_stopped;
   logic [1:0] sw_settle;

   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                  sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

   wire access = req.cyc && req.stb && !wb_ack_o;
   wire wr = access && req.we && req.sel[0];
   wire wr_ctrl = wr && req.adr == ADR_CTRL;
   wire wr_sweep = wr && req.adr == ADR_SWEEP;
   wire wr_cmd = wr && req.adr == ADR_CMD;
   wire stopped = mode != SWRS_RUN;
   wire cfg_ok = stopped && !mem_protect_o;
   wire sw_enabled = active[CTRL_SWRUN];
   wire sweep_done = wr_cmd && req.dat[CMD_SWEEP_DONE];
   wire store = wr_cmd && req.dat[CMD_STORE] && cfg_ok;
   wire const_on = active[CTRL_CONST];
   // Millisecond tick from the clock; sweep time is kept in whole ms
   wire tick_ms = sweep_cnt == CYC_PER_MS - 1;
   wire expired = const_on && sweep_ms_cnt >= sweep_ms;
   // Edges count only once both sync stages and the delay stage hold the pin
   wire sw_ready = sw_settle == 2'h3;
   wire sw_rise = sw_ready && sw_sync && !sw_prev;
   wire sw_fall = sw_ready && !sw_sync && sw_prev;
   wire run_block = sw_enabled && !sw_sync;
   wire sw_run_try = sw_enabled && sw_rise;
   wire run_plain = !fatal && mode != SWRS_STOP_FAULT;
   wire sw_run_ok = sw_run_try && run_plain;
   wire sw_blink_go = sw_run_try && !run_plain && !blink_on;
   wire half_done = hold_cnt >= HOLD_CYC;
   wire clr_done = blink_on && clr_step == 2'h1 && sw_rise && half_done;
   wire sw_req_run = wr_cmd && req.dat[CMD_RUN_REQ] && run_plain;
   wire to_run = (sw_run_ok || sw_req_run) && !run_block;
   wire to_stop_sw = sw_enabled && sw_fall && mode == SWRS_RUN;
   wire sw_stop_req = wr_cmd && req.dat[CMD_STOP_SW];
   wire [8:0] sweep_wdat = req.dat[8:0];
   wire sweep_valid = sweep_wdat >= 9'(SWEEP_MIN_MS) &&
                      sweep_wdat <= 9'(SWEEP_MAX_MS);
   swrs_mode_type stop_mode;
   assign stop_mode = active[CTRL_STOPIO] ? SWRS_STOP_IO : SWRS_STOP_NOIO;
   // A program stop parks the outputs even where stop keeps I/O scanned
   wire hold_default = prog_stopped && stopped;

   // Unmapped offsets read as zero but are still acknowledged
   logic [31:0] rd_data;
   always_comb begin
      rd_data = 32'h0;
      case (req.adr)
         ADR_CTRL: rd_data = {20'h0, active, ctrl};
         ADR_SWEEP: rd_data = {23'h0, sweep_ms};
         ADR_STATUS: rd_data = {23'h0, fatal,
                               nonfatal, oversweep_contact_o, sw_sync,
                               blink_on, stop_pend, mem_protect_o,
                               2'(mode)};
         default: rd_data = 32'h0;
      endcase
   end

   // Ack masks the access for one cycle, so a held request is taken again every second cycle
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= access;
         wb_dat_o <= access ? rd_data : 32'h0;
      end
   end

   // Two stages for the asynchronous switch; only the second is read
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sw_meta <= 1'b0;
         sw_sync <= 1'b0;
         sw_prev <= 1'b0;
      end else begin
         sw_meta <= run_switch_i;
         sw_sync <= sw_meta;
         sw_prev <= sw_sync;
      end
   end

   // A switch held at Run through reset must not look like a fresh move
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sw_settle <= 2'h0;
      end else if (sw_settle != 2'h3) begin
         sw_settle <= sw_settle + 2'h1;
      end
   end

   // Edited ctrl copy is staged; only a store makes it active, and only in stop; sweep time is written directly in any mode
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl <= CTRL_RESET;
         active <= CTRL_RESET;
         sweep_ms <= SWEEP_RESET;
      end else begin
         if (wr_ctrl && cfg_ok)
            ctrl <= req.dat[5:0];
         if (store)
            active <= ctrl;
         if (wr_sweep && sweep_valid)
            sweep_ms <= sweep_wdat;
      end
   end

   // Sweep timer: counts whole ms from each sweep start
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sweep_cnt <= 32'h0;
         sweep_ms_cnt <= 9'h0;
         overrun <= 1'b0;
      end else if (sweep_done) begin
         sweep_cnt <= 32'h0;
         sweep_ms_cnt <= 9'h0;
         overrun <= 1'b0;
      end else begin
         sweep_cnt <= tick_ms ? 32'h0 : sweep_cnt + 32'h1;
         // Saturates so a stalled sequencer cannot wrap the count
         if (tick_ms && sweep_ms_cnt != 9'h1FF)
            sweep_ms_cnt <= sweep_ms_cnt + 9'h1;
         // Expiry only flags; the sweep runs on to its end
         if (expired)
            overrun <= 1'b1;
      end
   end

   // Overrun pipeline across sweep boundaries
   // The log follows an overrun by one sweep end, the contact by two
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pend_log <= 1'b0;
         pend_contact <= 1'b0;
         oversweep_contact_o <= 1'b0;
      end else if (!const_on) begin
         pend_log <= 1'b0;
         pend_contact <= 1'b0;
         oversweep_contact_o <= 1'b0;
      end else if (sweep_done) begin
         pend_log <= overrun || expired;
         pend_contact <= pend_log;
         if (pend_contact)
            oversweep_contact_o <= 1'b1;
         else if (!(overrun || expired) && !pend_log)
            oversweep_contact_o <= 1'b0;
      end
   end

   // Fault flags: a set command wins over a clear in the same cycle
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fatal <= 1'b0;
         nonfatal <= 1'b0;
      end else begin
         if (wr_cmd && req.dat[CMD_FATAL])
            fatal <= 1'b1;
         else if (clr_done || (wr_cmd && req.dat[CMD_CLEAR]))
            fatal <= 1'b0;
         if (wr_cmd && req.dat[CMD_NONFATAL])
            nonfatal <= 1'b1;
         else if (clr_done || (wr_cmd && req.dat[CMD_CLEAR]))
            nonfatal <= 1'b0;
      end
   end

   // Fault log strobe, one cycle
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fault_log_o <= 1'b0;
         fault_code_o <= 2'h0;
      end else begin
         fault_log_o <= 1'b0;
         if (sweep_done && const_on && pend_log) begin
            fault_log_o <= 1'b1;
            fault_code_o <= 2'h1;
         end else if (sweep_done && stop_pend) begin
            fault_log_o <= 1'b1;
            fault_code_o <= 2'h2;
         end
      end
   end

   // Mode machine
   // A program stop waits for the end of the sweep in progress
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode <= SWRS_STOP_NOIO;
         stop_pend <= 1'b0;
         prog_stopped <= 1'b0;
      end else begin
         if (wr_cmd && req.dat[CMD_STOP_REQ] && mode == SWRS_RUN)
            stop_pend <= 1'b1;
         case (mode)
            SWRS_RUN: begin
               prog_stopped <= 1'b0;
               if (run_block || to_stop_sw)
                  mode <= stop_mode;
               else if (stop_pend && sweep_done) begin
                  mode <= stop_mode;
                  stop_pend <= 1'b0;
                  prog_stopped <= 1'b1;
               end else if (wr_cmd && req.dat[CMD_FATAL])
                  mode <= SWRS_STOP_FAULT;
               else if (sw_stop_req)
                  mode <= stop_mode;
            end
            SWRS_STOP_NOIO, SWRS_STOP_IO: begin
               // A request left over from Run must not stop a later run
               stop_pend <= 1'b0;
               if (wr_cmd && req.dat[CMD_FATAL])
                  mode <= SWRS_STOP_FAULT;
               else if (to_run)
                  mode <= SWRS_RUN;
               else
                  mode <= stop_mode;
            end
            SWRS_STOP_FAULT: begin
               stop_pend <= 1'b0;
               if (clr_done && !run_block)
                  mode <= SWRS_RUN;
               else if (wr_cmd && req.dat[CMD_CLEAR])
                  mode <= stop_mode;
            end
            default: mode <= SWRS_STOP_NOIO;
         endcase
      end
   end

   // Fault-clear window: Run hold, Stop hold, back to Run
   // Holds count from the last switch edge; a short hold starts over
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         blink_on <= 1'b0;
         blink_cnt <= 32'h0;
         hold_cnt <= 32'h0;
         clr_step <= 2'h0;
      end else if (sw_blink_go) begin
         blink_on <= 1'b1;
         blink_cnt <= 32'h0;
         hold_cnt <= 32'h0;
         clr_step <= 2'h0;
      end else if (blink_on) begin
         blink_cnt <= blink_cnt + 32'h1;
         if (clr_done || blink_cnt >= BLINK_CYC - 1)
            blink_on <= 1'b0;
         if (sw_rise || sw_fall)
            hold_cnt <= 32'h0;
         else if (!half_done)
            hold_cnt <= hold_cnt + 32'h1;
         case (clr_step)
            2'h0: if (sw_fall && half_done) clr_step <= 2'h1;
            2'h1: if (sw_rise && half_done) clr_step <= 2'h2;
            default: clr_step <= clr_step;
         endcase
         if (sw_fall && !half_done)
            clr_step <= 2'h0;
         if (clr_step == 2'h1 && sw_rise && !half_done)
            clr_step <= 2'h0;
      end
   end

   // Blink phase starts lit so the LED answers the switch at once
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         half_cnt <= 32'h0;
         blink_phase <= 1'b0;
      end else if (!blink_on) begin
         half_cnt <= 32'h0;
         blink_phase <= 1'b1;
      end else if (half_cnt >= BLINK_HALF_CYC - 1) begin
         half_cnt <= 32'h0;
         blink_phase <= !blink_phase;
      end else begin
         half_cnt <= half_cnt + 32'h1;
      end
   end

   // Outputs registered
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         logic_exec_o <= 1'b0;
         io_scan_o <= 1'b0;
         comms_en_o <= 1'b0;
         outputs_default_o <= 1'b1;
         load_flash_o <= 1'b0;
         mem_protect_o <= 1'b0;
         run_led_o <= 1'b0;
      end else begin
         logic_exec_o <= mode == SWRS_RUN;
         io_scan_o <= (mode == SWRS_RUN || mode == SWRS_STOP_IO) &&
            !hold_default;
         // Comms never stop: programmer and module service run in every mode
         comms_en_o <= 1'b1;
         outputs_default_o <= (mode != SWRS_RUN && mode != SWRS_STOP_IO) ||
            hold_default;
         load_flash_o <= active[CTRL_FLASH];
         // Protection follows the switch: Stop locks ctrl writes and store, Run frees them
         mem_protect_o <= active[CTRL_SWMP] && !sw_sync;
         run_led_o <= blink_on ? blink_phase : mode == SWRS_RUN;
      end
   end
endmodule : swrs_ctrl

//--- src/swrs_pkg.sv
/*
 Package for the sweep timing and run/stop controller: register map,
 field positions, reset values, timing counts and carrier types.
 Assumes a 250 MHz controller clock.
*/
package swrs_pkg;
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
   localparam int unsigned SWEEP_MIN_MS = 5;
   localparam int unsigned SWEEP_MAX_MS = 500;
   localparam int unsigned MARGIN_MS = 10;
   localparam int unsigned BLINK_MS = 5000;
   localparam int unsigned HOLD_MS = 500;
   localparam int unsigned BLINK_CYC = BLINK_MS * CYC_PER_MS;
   localparam int unsigned HOLD_CYC = HOLD_MS * CYC_PER_MS;
   localparam int unsigned BLINK_HALF_CYC = HOLD_CYC / 2;

   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_SWEEP = 4'h4;
   localparam logic [3:0] ADR_STATUS = 4'h8;
   localparam logic [3:0] ADR_CMD = 4'hC;

   localparam int CTRL_CONST = 0;
   localparam int CTRL_STOPIO = 1;
   localparam int CTRL_FLASH = 2;
   localparam int CTRL_SWRUN = 3;
   localparam int CTRL_SWMP = 4;
   localparam int CTRL_CFGWE = 5;
   localparam logic [5:0] CTRL_RESET = 6'h08;
   localparam logic [8:0] SWEEP_RESET = 9'h064;

   localparam int CMD_SWEEP_DONE = 0;
   localparam int CMD_STOP_REQ = 1;
   localparam int CMD_RUN_REQ = 2;
   localparam int CMD_FATAL = 3;
   localparam int CMD_NONFATAL = 4;
   localparam int CMD_CLEAR = 5;
   localparam int CMD_STORE = 6;
   localparam int CMD_STOP_SW = 7;

   typedef enum logic [1:0] {
      SWRS_RUN, SWRS_STOP_NOIO, SWRS_STOP_IO, SWRS_STOP_FAULT
   } swrs_mode_type;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [3:0] adr;
      logic [31:0] dat;
   } swrs_wb_req_type;
endpackage : swrs_pkg
